// File: hw/acf_consts.vh
// Constants for the ATA command layer block: register offsets, fields,
// command codes and timing counts. Included by the design modules.
`ifndef ACF_CONSTS_VH
`define ACF_CONSTS_VH
// Register byte offsets on the AHB-Lite slave.
`define ACF_OFS_FEAT      8'h00
`define ACF_OFS_SCNT      8'h04
`define ACF_OFS_SNUM      8'h08
`define ACF_OFS_CYL       8'h0c
`define ACF_OFS_DRVHD     8'h10
`define ACF_OFS_CMD       8'h14
`define ACF_OFS_STATUS    8'h18
`define ACF_OFS_ISTAT     8'h1c
`define ACF_OFS_IMASK     8'h20
`define ACF_OFS_CTRL      8'h24
`define ACF_OFS_XFER      8'h28
`define ACF_OFS_PARAM     8'h2c
// Drive/head fields.
`define ACF_DH_LBA_BIT    6
`define ACF_DH_DRV_BIT    4
// Status and error byte bits.
`define ACF_ST_BSY        7
`define ACF_ST_DRDY       6
`define ACF_ST_ERR        0
`define ACF_ER_ABRT       2
// Interrupt status bits.
`define ACF_IRQ_CMD       0
`define ACF_IRQ_DONE      1
`define ACF_IRQ_ABORT     2
// Command codes.
`define ACF_CMD_NOP       8'h00
`define ACF_CMD_RD_SEC    8'h20
`define ACF_CMD_WR_SEC    8'h30
`define ACF_CMD_WR_NOER   8'h38
`define ACF_CMD_VFY0      8'h40
`define ACF_CMD_VFY1      8'h41
`define ACF_CMD_RD_MULT   8'hc4
`define ACF_CMD_WR_MULT   8'hc5
`define ACF_CMD_RD_DMA    8'hc8
`define ACF_CMD_WRM_NOER  8'hcd
`define ACF_CMD_RD_NMAX   8'hf8
`define ACF_CMD_SET_MAX   8'hf9
`define ACF_CMD_IDENT     8'hec
// Largest data frame in doublewords.
`define ACF_MAX_FRAME_DW  12'd2048
// LED blink half period: 100 ms at the 10 MHz clock, in cycles.
`define ACF_BLINK_CYC     24'd1000000
`endif

// File: hw/acf_decode.v
// Command code decoder: classifies one command code.
// Assumes a stable code input; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "acf_consts.vh"
module acf_decode
(
    // Code in
    input  wire [7:0] code,
    // Class out
    output reg        is_dma_in,
    output reg        is_nop,
    output reg        is_supported,
    output reg        uses_head,
    output reg        uses_lba
);
    always @*
    begin
        is_dma_in    = 1'b0;
        is_nop       = 1'b0;
        is_supported = 1'b1;
        uses_head    = 1'b1;
        uses_lba     = 1'b1;
        case (code)
            `ACF_CMD_RD_SEC, `ACF_CMD_RD_MULT, `ACF_CMD_RD_DMA:
                is_dma_in = 1'b1;
            `ACF_CMD_WR_SEC, `ACF_CMD_WR_MULT,
            `ACF_CMD_VFY0, `ACF_CMD_VFY1:
                is_nop = 1'b0;
            `ACF_CMD_WR_NOER, `ACF_CMD_WRM_NOER:
                is_nop = 1'b0;
            `ACF_CMD_SET_MAX:
                uses_lba = 1'b1;
            `ACF_CMD_RD_NMAX:
            begin
                uses_head = 1'b0;
                uses_lba  = 1'b0;
            end
            `ACF_CMD_IDENT:
            begin
                is_dma_in = 1'b1;
                uses_head = 1'b0;
                uses_lba  = 1'b0;
            end
            `ACF_CMD_NOP, 8'he5, 8'h98, 8'h90, 8'he7, 8'he3, 8'h97,
            8'he1, 8'h95, 8'he4, 8'h03, 8'hf1, 8'hf2, 8'hf3, 8'hf4,
            8'hf5, 8'hf6, 8'hef, 8'hc6, 8'hb0, 8'he2, 8'h96, 8'he0,
            8'h94, 8'he8:
            begin
                is_nop    = 1'b1;
                uses_head = 1'b0;
                uses_lba  = 1'b0;
            end
            8'hc0, 8'h87, 8'hca:
                is_nop = 1'b1;
            default:
            begin
                is_supported = 1'b0;
                uses_head    = 1'b0;
                uses_lba     = 1'b0;
            end
        endcase
    end
endmodule // acf_decode
`default_nettype wire

// File: hw/acf_cmd_flow.v
// ATA command layer: task file over AHB-Lite, command decode, DMA data-in
// flow toward the transport layer, activity LED and card-detect pins.
// Assumes one 10 MHz clock, synchronous reset, transport handshakes on clk.
//
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "acf_consts.vh"
module acf_cmd_flow
(
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    output reg         irq,
    // Data preparation (media side)
    input  wire        data_ready,
    input  wire        data_error,
    // Transport layer
    output reg         tl_data_req,
    output reg  [11:0] tl_data_dw,
    input  wire        tl_data_done,
    output reg         tl_reg_req,
    output reg  [7:0]  tl_reg_status,
    output reg  [7:0]  tl_reg_error,
    output reg         tl_reg_ibit,
    input  wire        tl_reg_done,
    // Pins
    input  wire        card_detect_input,
    output reg         card_detect_output,
    output reg         activity_led_out_n
);
    localparam [1:0] DEVICE_IDLE_STATE       = 2'd0;
    localparam [1:0] DMA_IN_PREPARE_STATE    = 2'd1;
    localparam [1:0] SEND_DATA_FRAME_STATE   = 2'd2;
    localparam [1:0] SEND_STATUS_FRAME_STATE = 2'd3;
    localparam [23:0] BLINK_CYC = `ACF_BLINK_CYC;

    function [11:0] frame_dw;
        input [19:0] left;
        begin
            if (left > {8'h00, `ACF_MAX_FRAME_DW})
                frame_dw = `ACF_MAX_FRAME_DW;
            else
                frame_dw = left[11:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    reg  [7:0]  features_reg;
    reg  [7:0]  sector_count_reg;
    reg  [7:0]  sector_number_reg;
    reg  [15:0] cylinder_regs;
    reg  [7:0]  drive_head_reg;
    reg  [7:0]  cmd_r;
    reg  [2:0]  istat_r;
    reg  [2:0]  imask_r;
    reg  [1:0]  led_mode_r;
    reg  [1:0]  state_r;
    reg  [19:0] dw_left_r;
    reg  [27:0] param_r;
    reg         abort_r;
    reg         wr_pend_r;
    reg  [7:0]  wr_addr_r;
    reg  [23:0] blink_cnt_r;
    reg         blink_r;
    wire        dec_dma_in;
    wire        dec_nop;
    wire        dec_sup;
    wire        dec_head;
    wire        dec_lba;
    wire        busy = (state_r != DEVICE_IDLE_STATE);
    wire        cmd_wr = wr_pend_r && (wr_addr_r == `ACF_OFS_CMD);
    wire        start = cmd_wr && !busy;
    wire [7:0]  new_cmd = hwdata[7:0];
    wire [2:0]  ev;

    acf_decode u_dec
    (
        .code         (new_cmd),
        .is_dma_in    (dec_dma_in),
        .is_nop       (dec_nop),
        .is_supported (dec_sup),
        .uses_head    (dec_head),
        .uses_lba     (dec_lba)
    );

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states; writes land in the data phase.
    always @(posedge clk)
    begin
        if (rst)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_r <= 1'b0;
            if (hsel && hready && htrans[1])
            begin
                wr_pend_r <= hwrite;
                wr_addr_r <= haddr;
                hrdata    <= 32'h00000000;
                if (!hwrite)
                begin
                    case (haddr)
                        `ACF_OFS_FEAT:   hrdata <= {24'h0, features_reg};
                        `ACF_OFS_SCNT:   hrdata <= {24'h0, sector_count_reg};
                        `ACF_OFS_SNUM:   hrdata <= {24'h0, sector_number_reg};
                        `ACF_OFS_CYL:    hrdata <= {16'h0, cylinder_regs};
                        `ACF_OFS_DRVHD:  hrdata <= {24'h0, drive_head_reg};
                        `ACF_OFS_CMD:    hrdata <= {24'h0, cmd_r};
                        `ACF_OFS_STATUS: hrdata <= {14'h0, state_r,
                                                    tl_reg_error,
                                                    tl_reg_status};
                        `ACF_OFS_ISTAT:  hrdata <= {29'h0, istat_r};
                        `ACF_OFS_IMASK:  hrdata <= {29'h0, imask_r};
                        `ACF_OFS_CTRL:   hrdata <= {30'h0, led_mode_r};
                        `ACF_OFS_XFER:   hrdata <= {12'h0, dw_left_r};
                        `ACF_OFS_PARAM:  hrdata <= {4'h0, param_r};
                        default:         hrdata <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Task file; parameter writes while busy are dropped so a running
    // command keeps the values it started with.
    always @(posedge clk)
    begin
        if (rst)
        begin
            features_reg      <= 8'h00;
            sector_count_reg  <= 8'h00;
            sector_number_reg <= 8'h00;
            cylinder_regs     <= 16'h0000;
            drive_head_reg    <= 8'h00;
            imask_r           <= 3'h0;
            led_mode_r        <= 2'd0;
        end
        else if (wr_pend_r)
        begin
            case (wr_addr_r)
                `ACF_OFS_FEAT:  if (!busy) features_reg <= hwdata[7:0];
                `ACF_OFS_SCNT:  if (!busy) sector_count_reg <= hwdata[7:0];
                `ACF_OFS_SNUM:  if (!busy) sector_number_reg <= hwdata[7:0];
                `ACF_OFS_CYL:   if (!busy) cylinder_regs <= hwdata[15:0];
                `ACF_OFS_DRVHD: if (!busy) drive_head_reg <= hwdata[7:0];
                `ACF_OFS_IMASK: imask_r <= hwdata[2:0];
                `ACF_OFS_CTRL:  led_mode_r <= hwdata[1:0];
                default:        imask_r <= imask_r;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command flow. A command write while busy is ignored.
    assign ev = {(state_r == SEND_STATUS_FRAME_STATE) && tl_reg_done
                     && abort_r,
                 (state_r == SEND_STATUS_FRAME_STATE) && tl_reg_done,
                 start};

    always @(posedge clk)
    begin
        if (rst)
        begin
            state_r       <= DEVICE_IDLE_STATE;
            cmd_r         <= 8'h00;
            dw_left_r     <= 20'h00000;
            param_r       <= 28'h0000000;
            abort_r       <= 1'b0;
            tl_data_req   <= 1'b0;
            tl_data_dw    <= 12'h000;
            tl_reg_req    <= 1'b0;
            tl_reg_status <= 8'h40;
            tl_reg_error  <= 8'h00;
            tl_reg_ibit   <= 1'b0;
        end
        else
        begin
            case (state_r)
                DEVICE_IDLE_STATE:
                begin
                    if (start)
                    begin
                        cmd_r   <= new_cmd;
                        abort_r <= !dec_sup && !dec_nop;
                        tl_reg_status[`ACF_ST_BSY] <= 1'b1;
                        if (dec_lba && drive_head_reg[`ACF_DH_LBA_BIT])
                            param_r <= {drive_head_reg[3:0],
                                        cylinder_regs,
                                        sector_number_reg};
                        else if (dec_head)
                            param_r <= {drive_head_reg[3:0],
                                        cylinder_regs,
                                        sector_number_reg};
                        else
                            param_r <= {3'h0,
                                        drive_head_reg[`ACF_DH_DRV_BIT],
                                        24'h000000};
                        // Zero sectors means 256, the top bit of the count.
                        dw_left_r <= {4'h0, sector_count_reg == 8'h00,
                                      sector_count_reg, 7'h00};
                        if (dec_sup && dec_dma_in)
                            state_r <= DMA_IN_PREPARE_STATE;
                        else
                            state_r <= SEND_STATUS_FRAME_STATE;
                    end
                end
                DMA_IN_PREPARE_STATE:
                begin
                    if (data_error || dw_left_r == 20'h00000)
                    begin
                        abort_r <= abort_r | data_error;
                        state_r <= SEND_STATUS_FRAME_STATE;
                    end
                    else if (data_ready)
                    begin
                        tl_data_dw  <= frame_dw(dw_left_r);
                        tl_data_req <= 1'b1;
                        state_r     <= SEND_DATA_FRAME_STATE;
                    end
                end
                SEND_DATA_FRAME_STATE:
                begin
                    if (tl_data_done)
                    begin
                        tl_data_req <= 1'b0;
                        dw_left_r   <= dw_left_r
                                       - {8'h00, tl_data_dw};
                        state_r     <= DMA_IN_PREPARE_STATE;
                    end
                end
                SEND_STATUS_FRAME_STATE:
                begin
                    if (!tl_reg_req && !tl_reg_done)
                    begin
                        tl_reg_req  <= 1'b1;
                        tl_reg_ibit <= 1'b1;
                        tl_reg_status <= {1'b0, 1'b1, 5'h00, abort_r};
                        tl_reg_error  <= {5'h00, abort_r, 2'h0};
                    end
                    else if (tl_reg_done)
                    begin
                        tl_reg_req  <= 1'b0;
                        tl_reg_ibit <= 1'b0;
                        state_r     <= DEVICE_IDLE_STATE;
                    end
                end
                default: state_r <= DEVICE_IDLE_STATE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: a new event wins over a write-one-to-clear.
    always @(posedge clk)
    begin
        if (rst)
        begin
            istat_r <= 3'h0;
            irq     <= 1'b0;
        end
        else
        begin
            if (wr_pend_r && wr_addr_r == `ACF_OFS_ISTAT)
                istat_r <= (istat_r & ~hwdata[2:0]) | ev;
            else
                istat_r <= istat_r | ev;
            irq <= |((istat_r | ev) & imask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // LED: mode 0 follows activity, 1 on, 2 blink, 3 off. The pin is
    // active low. Card-detect in is left unread by design.
    always @(posedge clk)
    begin
        if (rst)
        begin
            blink_cnt_r        <= 24'h000000;
            blink_r            <= 1'b0;
            activity_led_out_n <= 1'b1;
            card_detect_output <= 1'b0;
        end
        else
        begin
            card_detect_output <= 1'b1;
            if (blink_cnt_r >= BLINK_CYC - 24'h000001)
            begin
                blink_cnt_r <= 24'h000000;
                blink_r     <= ~blink_r;
            end
            else
                blink_cnt_r <= blink_cnt_r + 24'h000001;
            case (led_mode_r)
                2'd0:    activity_led_out_n <= ~busy;
                2'd1:    activity_led_out_n <= 1'b0;
                2'd2:    activity_led_out_n <= blink_r;
                default: activity_led_out_n <= 1'b1;
            endcase
        end
    end
endmodule // acf_cmd_flow
`default_nettype wire

// File: tb/acf_cmd_flow_assertions.sv
// Checker for the command flow block: transport handshakes and pins.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module acf_flow_checker
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Media side
    input wire logic        data_ready,
    // Transport layer
    input wire logic        tl_data_req,
    input wire logic [11:0] tl_data_dw,
    input wire logic        tl_data_done,
    input wire logic        tl_reg_req,
    input wire logic [7:0]  tl_reg_status,
    input wire logic [7:0]  tl_reg_error,
    input wire logic        tl_reg_ibit,
    input wire logic        tl_reg_done,
    // Pins
    input wire logic        card_detect_output
);
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    sequence s_frame_end;
        tl_data_req && tl_data_done;
    endsequence
    sequence s_status_end;
        tl_reg_req && tl_reg_done;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_frame_size: assert property (
        tl_data_req |-> tl_data_dw != 12'h000 && tl_data_dw <= 12'h800)
        else $error("data frame size out of range");
    a_data_hold: assert property (
        tl_data_req && !tl_data_done |=> tl_data_req)
        else $error("data request dropped before done");
    a_frame_return: assert property (s_frame_end |=> !tl_data_req)
        else $error("data request held after done");
    a_data_cause: assert property (
        $rose(tl_data_req) |-> $past(data_ready))
        else $error("data request without ready data");
    a_one_request: assert property (!(tl_data_req && tl_reg_req))
        else $error("data and status requests together");
    a_status_hold: assert property (
        tl_reg_req && !tl_reg_done |=> tl_reg_req ##0 $stable(tl_reg_status))
        else $error("status frame request not held");
    a_ibit_set: assert property (tl_reg_req |-> tl_reg_ibit)
        else $error("status frame without interrupt bit");
    a_idle_return: assert property (s_status_end |=> !tl_reg_req [*2])
        else $error("status request held after done");
    a_abort_code: assert property (
        tl_reg_req && tl_reg_status[0] |-> tl_reg_error[2])
        else $error("error status without abort code");
    a_detect_out: assert property (!$past(rst) |-> card_detect_output)
        else $error("card detect output low while powered");
endmodule // acf_flow_checker
bind acf_cmd_flow acf_flow_checker chk
(
    .clk(clk), .rst(rst), .data_ready(data_ready),
    .tl_data_req(tl_data_req), .tl_data_dw(tl_data_dw),
    .tl_data_done(tl_data_done), .tl_reg_req(tl_reg_req),
    .tl_reg_status(tl_reg_status), .tl_reg_error(tl_reg_error),
    .tl_reg_ibit(tl_reg_ibit), .tl_reg_done(tl_reg_done),
    .card_detect_output(card_detect_output)
);
`default_nettype wire

// File: tb/acf_link_model.sv
// Transport layer model: completes data and status frame requests.
// Assumes level requests held until a one-cycle done pulse.
`timescale 1ns/1ps
`default_nettype none
module acf_link_model
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Extra cycles before each completion, for slow answers
    input wire logic [3:0]  lag,
    // Requests from the device
    input wire logic        tl_data_req,
    input wire logic [11:0] tl_data_dw,
    input wire logic        tl_reg_req,
    input wire logic [7:0]  tl_reg_status,
    input wire logic [7:0]  tl_reg_error,
    // Completions and tallies
    output logic            tl_data_done,
    output logic            tl_reg_done,
    output logic [15:0]     n_frames,
    output logic [19:0]     n_dw,
    output logic [15:0]     n_regs,
    output logic [15:0]     last_st
);
    logic [3:0] wait_r;
    // The cycle of a done pulse is skipped so a request is never
    // completed twice while the device is still dropping it.
    always @(posedge clk)
    begin
        tl_data_done <= 1'b0;
        tl_reg_done <= 1'b0;
        if (rst)
        begin
            wait_r <= 4'h0;
            n_frames <= 16'h0;
            n_dw <= 20'h0;
            n_regs <= 16'h0;
            last_st <= 16'h0;
        end
        else if ((tl_data_req || tl_reg_req) && !tl_data_done && !tl_reg_done)
        begin
            if (wait_r < lag)
                wait_r <= wait_r + 4'h1;
            else
            begin
                wait_r <= 4'h0;
                if (tl_data_req)
                begin
                    tl_data_done <= 1'b1;
                    n_frames <= n_frames + 16'h1;
                    n_dw <= n_dw + {8'h0, tl_data_dw};
                end
                else
                begin
                    tl_reg_done <= 1'b1;
                    n_regs <= n_regs + 16'h1;
                    last_st <= {tl_reg_error, tl_reg_status};
                end
            end
        end
    end
endmodule // acf_link_model
`default_nettype wire

// File: tb/tb_acf_cmd_flow.sv
// Testbench for the command flow block: bus tasks, scenarios, verdict.
// Assumes the design constants header and the transport model.
`timescale 1ns/1ps
`default_nettype none
`include "acf_consts.vh"
module tb_acf_cmd_flow;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic data_ready = 1'b0;
    logic data_error = 1'b0;
    logic card_detect_input = 1'b1;
    logic [3:0] lag = 4'h0;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, irq, tl_data_req, tl_data_done;
    wire logic tl_reg_req, tl_reg_ibit, tl_reg_done;
    wire logic card_detect_output, activity_led_out_n;
    wire logic [11:0] tl_data_dw;
    wire logic [7:0] tl_reg_status, tl_reg_error;
    wire logic [15:0] n_frames, n_regs, last_st;
    wire logic [19:0] n_dw;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    ////////////////////////////////////////////////////////////////////////
    acf_cmd_flow dut
    (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .irq(irq), .data_ready(data_ready),
        .data_error(data_error), .tl_data_req(tl_data_req),
        .tl_data_dw(tl_data_dw), .tl_data_done(tl_data_done),
        .tl_reg_req(tl_reg_req), .tl_reg_status(tl_reg_status),
        .tl_reg_error(tl_reg_error), .tl_reg_ibit(tl_reg_ibit),
        .tl_reg_done(tl_reg_done), .card_detect_input(card_detect_input),
        .card_detect_output(card_detect_output),
        .activity_led_out_n(activity_led_out_n)
    );
    acf_link_model link
    (
        .clk(clk), .rst(rst), .lag(lag), .tl_data_req(tl_data_req),
        .tl_data_dw(tl_data_dw), .tl_reg_req(tl_reg_req),
        .tl_reg_status(tl_reg_status), .tl_reg_error(tl_reg_error),
        .tl_data_done(tl_data_done), .tl_reg_done(tl_reg_done),
        .n_frames(n_frames), .n_dw(n_dw), .n_regs(n_regs), .last_st(last_st)
    );
    always #50 clk = ~clk;
    // The whole run needs far fewer cycles; a hang ends here.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            n_mismatch++;
            $display("[ERR] %0t run too long", $time);
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        rd = hrdata;
        chk(hresp, 1'b0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic run_cmd(input logic [7:0] code, input logic [7:0] sc,
                           input logic err, input logic poke,
                           input logic [15:0] fr, input logic [19:0] dw,
                           input logic [15:0] st, input logic [2:0] ist,
                           input logic irq_exp);
        logic [15:0] f0;
        logic [19:0] d0;
        logic [15:0] r0;
        logic [31:0] x;
        int n;
        f0 = n_frames;
        d0 = n_dw;
        r0 = n_regs;
        wr(`ACF_OFS_ISTAT, 32'h7);
        wr(`ACF_OFS_SCNT, {24'h0, sc});
        wr(`ACF_OFS_DRVHD, 32'he0);
        data_ready <= 1'b0;
        data_error <= err;
        wr(`ACF_OFS_CMD, {24'h0, code});
        if (poke)
        begin
            wr(`ACF_OFS_CMD, 32'h5a);
            wr(`ACF_OFS_SCNT, 32'h9);
            chk(activity_led_out_n, 1'b0);
        end
        data_ready <= !err;
        n = 0;
        while (n_regs == r0 && n < 60000)
        begin
            @(posedge clk);
            n++;
        end
        data_error <= 1'b0;
        chk(n_regs - r0, 32'h1);
        chk(n_frames - f0, fr);
        chk(n_dw - d0, dw);
        chk(last_st, st);
        bus(1'b0, `ACF_OFS_ISTAT, 32'h0, x);
        chk(x[2:0], ist);
        chk(irq, irq_exp);
        wr(`ACF_OFS_ISTAT, 32'h7);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        chk(activity_led_out_n, 1'b1);
    endtask
    task automatic t_pins();
        logic [31:0] x;
        card_detect_input <= 1'b0;
        repeat (2) @(posedge clk);
        chk(card_detect_output, 1'b1);
        wr(`ACF_OFS_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        chk(activity_led_out_n, 1'b0);
        wr(`ACF_OFS_CTRL, 32'h3);
        repeat (2) @(posedge clk);
        chk(activity_led_out_n, 1'b1);
        wr(`ACF_OFS_CTRL, 32'h2);
        repeat (2) @(posedge clk);
        chk(activity_led_out_n, 1'b0);
        wr(`ACF_OFS_CTRL, 32'h0);
        wr(8'h3c, 32'hffff_ffff);
        bus(1'b0, 8'h3c, 32'h0, x);
        chk(x, 32'h0);
        card_detect_input <= 1'b1;
        $display("test pins done");
    endtask
    task automatic t_dma();
        wr(`ACF_OFS_IMASK, 32'h2);
        lag <= 4'h0;
        run_cmd(`ACF_CMD_RD_SEC, 8'd1, 0, 0, 1, 128, 16'h40, 3'b011, 1);
        lag <= 4'h3;
        run_cmd(`ACF_CMD_RD_DMA, 8'd17, 0, 0, 2, 2176, 16'h40, 3'b011, 1);
        run_cmd(`ACF_CMD_RD_MULT, 8'd0, 0, 0, 16, 32768, 16'h40, 3'b011, 1);
        $display("test dma done");
    endtask
    task automatic t_busy();
        wr(`ACF_OFS_IMASK, 32'h0);
        run_cmd(`ACF_CMD_RD_SEC, 8'd1, 0, 1, 1, 128, 16'h40, 3'b011, 0);
        $display("test busy done");
    endtask
    task automatic t_abort();
        wr(`ACF_OFS_IMASK, 32'h4);
        run_cmd(`ACF_CMD_RD_SEC, 8'd32, 1, 0, 0, 0, 16'h441, 3'b111, 1);
        run_cmd(8'h5a, 8'd1, 0, 0, 0, 0, 16'h441, 3'b111, 1);
        $display("test abort done");
    endtask
    task automatic t_nondata();
        logic [7:0] codes [9] = '{8'h00, 8'h30, 8'h38, 8'h40, 8'h41,
                                  8'hc5, 8'hcd, 8'hf8, 8'hf9};
        wr(`ACF_OFS_IMASK, 32'h0);
        foreach (codes[i])
            run_cmd(codes[i], 8'd1, 0, 0, 0, 0, 16'h40, 3'b011, 0);
        $display("test nondata done");
    endtask
    task automatic t_param();
        logic [31:0] x;
        wr(`ACF_OFS_SNUM, 32'h12);
        wr(`ACF_OFS_CYL, 32'h3456);
        wr(`ACF_OFS_DRVHD, 32'hb7);
        wr(`ACF_OFS_CMD, 32'h40);
        bus(1'b0, `ACF_OFS_PARAM, 32'h0, x);
        chk(x, 32'h0734_5612);
        repeat (12) @(posedge clk);
        wr(`ACF_OFS_CMD, 32'he5);
        bus(1'b0, `ACF_OFS_PARAM, 32'h0, x);
        chk(x, 32'h0100_0000);
        repeat (12) @(posedge clk);
        wr(`ACF_OFS_DRVHD, 32'hf9);
        wr(`ACF_OFS_CMD, 32'hc0);
        bus(1'b0, `ACF_OFS_PARAM, 32'h0, x);
        chk(x, 32'h0934_5612);
        $display("test param done");
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_pins();
        t_dma();
        t_busy();
        t_abort();
        t_nondata();
        t_param();
        report_and_stop();
    end
endmodule // tb_acf_cmd_flow
`default_nettype wire
